// ---- hw/pcs_top.sv ----
// Program counter, paging and return stack sequencing unit.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"
module pcs_top #(
  parameter int PROG_WORDS = `PCS_PROG_WORDS
) (
  // Clock and reset.
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  // Decoder request.
  input  wire pcs_pkg::pcs_req_t       req_i,
  // High-byte latch value held by the core.
  input  wire logic [`PCS_LATCH_W-1:0] latch_i,
  // Program memory address and low byte read-back.
  output logic      [`PCS_PC_W-1:0]    pc_o,
  output logic      [7:0]              pc_low_byte_o
);
  import pcs_pkg::*;

  // Whole state of the counter.
  typedef struct packed {
    logic [`PCS_PC_W-1:0] pc;  // Program counter.
  } pcs_top_state_t;

  pcs_top_state_t st_r;    // Registered state.
  pcs_top_state_t st_nxt;  // Next state.

  logic [`PCS_PC_W-1:0] top;        // Stack top.
  logic [`PCS_PC_W-1:0] branch_pc;  // Paged branch address.
  logic [`PCS_PC_W-1:0] low_pc;     // Computed-jump address.
  logic                 push;       // Save return address.
  logic                 pop;        // Restore return address.
  logic [`PCS_PC_W-1:0] ret_addr;   // Address saved on push.

  // Paging logic.
  pcs_page #(.PROG_WORDS(PROG_WORDS)) u_page (
    .latch_i    (latch_i),
    .target_i   (req_i.target),
    .low_i      (req_i.low_data),
    .branch_pc_o(branch_pc),
    .low_pc_o   (low_pc)
  );

  // Return stack, hidden from software.
  pcs_stack u_stack (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .push_i     (push),
    .pop_i      (pop),
    .push_data_i(ret_addr),
    .top_o      (top)
  );  // [R08] [R09] [R14]

  // Call saves next word; vectoring saves current one.
  assign push = (req_i.op == PCS_OP_CALL) || (req_i.op == PCS_OP_VECTOR);  // [R10]
  assign pop  = (req_i.op == PCS_OP_RETURN);                               // [R11]
  assign ret_addr = (req_i.op == PCS_OP_VECTOR) ? st_r.pc : st_r.pc + 1'b1;

  // Next counter value; the latch is never written here.
  always_comb begin
    st_nxt = st_r;
    unique case (req_i.op)
      PCS_OP_STEP: begin
        st_nxt.pc = st_r.pc + 1'b1;  // [R01]
      end
      PCS_OP_HOLD: begin
        st_nxt.pc = st_r.pc;
      end
      PCS_OP_BRANCH, PCS_OP_CALL: begin
        st_nxt.pc = branch_pc;       // [R06]
      end
      PCS_OP_RETURN: begin
        st_nxt.pc = top;             // [R11] [R15] [R12]
      end
      PCS_OP_VECTOR: begin
        st_nxt.pc = `PCS_INT_VECTOR; // [R10]
      end
      PCS_OP_WRLOW: begin
        st_nxt.pc = low_pc;          // [R02] [R05] [R07]
      end
      default: begin
        st_nxt.pc = st_r.pc + 1'b1;
      end
    endcase
  end

  // Counter register; every reset clears it.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r.pc <= `PCS_PC_RESET;  // [R04]
    end else begin
      st_r <= st_nxt;
    end
  end

  // Only the low byte is visible to software.
  assign pc_o          = st_r.pc;
  assign pc_low_byte_o = st_r.pc[7:0];  // [R02] [R03]

  reset_clr_a: assert property (@(posedge clk_i)
    !reset_n_i |=> pc_o == `PCS_PC_RESET)  // [R04]
    else $error("counter not cleared by reset");
  low_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.op == PCS_OP_WRLOW |=> pc_o[7:0] == $past(req_i.low_data)
      && pc_o[11:8] == $past(latch_i[3:0]))  // [R05]
    else $error("low byte write did not load latch bits");
  branch_pg_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.op == PCS_OP_BRANCH || req_i.op == PCS_OP_CALL) |=>
      pc_o[10:0] == $past(req_i.target) && pc_o[11] == $past(latch_i[3]))  // [R06]
    else $error("branch address wrong");
  bit4_mask_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (PROG_WORDS <= 4096 && (req_i.op == PCS_OP_BRANCH || req_i.op == PCS_OP_WRLOW))
      |=> pc_o[12] == 1'b0)  // [R16]
    else $error("latch bit 4 used on small variant");
  call_ret_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (req_i.op == PCS_OP_CALL) ##1 (req_i.op == PCS_OP_RETURN)
      |=> pc_o == $past(pc_o, 2) + 1'b1)  // [R15]
    else $error("return did not restore call site");
  vector_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.op == PCS_OP_VECTOR |=> pc_o == `PCS_INT_VECTOR)  // [R10]
    else $error("vector address wrong");
  step_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    req_i.op == PCS_OP_STEP |=> pc_o == 13'($past(pc_o) + 1'b1))  // [R01]
    else $error("counter did not advance");
endmodule : pcs_top
`default_nettype wire

// ---- hw/pcs_defs.svh ----
// Constants for the program counter sequencing unit.
// How it works
// R01: Program counter is exactly 13 bits.
// R02: Low byte readable and writable by software.
// R03: Upper bits unreadable, loaded only via latch.
// R04: Any reset clears upper counter bits.
// R05: Low byte write copies latch bits 4:0 upward.
// R06: Call/jump: 11 instruction bits, latch bits 4:3.
// R07: Arithmetic low-byte write makes a computed jump.
// R08: Return stack holds eight 13-bit entries.
// R09: Stack pointer hidden from software.
// R10: Call or interrupt vectoring pushes the counter.
// R11: Return instructions pop top entry into counter.
// R12: Push and pop leave latch unchanged.
// R13: Stack is circular; ninth push overwrites first.
// R14: No overflow or underflow status exists.
// R15: Returns restore full 13-bit address.
// R16: Small variants ignore latch bit 4.
// R17: Address space reaches 8K words.
// R18: Software sets page bits before far branches.
// R19: Software avoids latch bit 4 as storage.
// R20: Stack pointer wraps modulo eight on pops.
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
`define PCS_PC_W        13
`define PCS_STACK_DEPTH 8
`define PCS_SP_W        3
`define PCS_BRANCH_W    11
`define PCS_UPPER_W     5
`define PCS_LATCH_W     8
`define PCS_PROG_WORDS  8192
`define PCS_PC_RESET    13'h0000
`define PCS_SP_RESET    3'h0
`define PCS_INT_VECTOR  13'h0004
`endif

// ---- hw/pcs_pkg.sv ----
// Types shared by the program counter sequencing unit.
`include "pcs_defs.svh"
package pcs_pkg;
  // Operation requested by the instruction decoder for this cycle.
  typedef enum logic [2:0] {
    PCS_OP_STEP   = 3'h0,  // Advance to next word.
    PCS_OP_HOLD   = 3'h1,  // Keep the counter.
    PCS_OP_BRANCH = 3'h2,  // Jump within page.
    PCS_OP_CALL   = 3'h3,  // Jump within page and save return.
    PCS_OP_RETURN = 3'h4,  // Restore from stack.
    PCS_OP_VECTOR = 3'h5,  // Interrupt vectoring.
    PCS_OP_WRLOW  = 3'h6   // Write to the low byte.
  } pcs_op_t;

  // Decoder request bundle.
  typedef struct packed {
    pcs_op_t                          op;          // Requested operation.
    logic [`PCS_BRANCH_W-1:0]         target;      // In-page branch target.
    logic [7:0]                       low_data;    // Data for low byte writes.
    logic                             ret_kind_lit; // Return with literal.
  } pcs_req_t;
endpackage : pcs_pkg

// ---- hw/pcs_stack.sv ----
// Circular eight-entry return address stack.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"
module pcs_stack #(
  parameter int DEPTH = `PCS_STACK_DEPTH,
  parameter int WIDTH = `PCS_PC_W
) (
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // Stack actions.
  input  wire logic             push_i,
  input  wire logic             pop_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  output logic      [WIDTH-1:0] top_o
);
  import pcs_pkg::*;
  localparam int SPW = $clog2(DEPTH);

  // Power-of-two depth lets the pointer wrap for free.
  initial begin
    if (DEPTH < 2 || (1 << SPW) != DEPTH) $error("DEPTH must be a power of two");
  end

  // Whole state of the stack.
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // Saved addresses.
    logic [SPW-1:0]              sp;   // Next free slot.
  } pcs_stk_state_t;

  pcs_stk_state_t st_r;   // Registered state.
  pcs_stk_state_t st_nxt; // Next state.

  // Push writes the free slot and advances; pop steps back; both wrap modulo depth.
  always_comb begin
    st_nxt = st_r;
    if (push_i) begin
      st_nxt.mem[st_r.sp] = push_data_i;   // [R10] [R13]
      st_nxt.sp = st_r.sp + 1'b1;          // [R13]
    end else if (pop_i) begin
      st_nxt.sp = st_r.sp - 1'b1;          // [R11] [R20]
    end
  end

  // Registers; memory is left as is on reset, pointer is cleared.
  always_ff @(posedge clk_i) begin
    st_r <= st_nxt;
    if (!reset_n_i) begin
      st_r.sp <= '0;
    end
  end

  // Top of stack is the slot below the pointer.
  assign top_o = st_r.mem[SPW'(st_r.sp - 1'b1)];  // [R15]

  // Ninth push lands in the same slot as the first.
  wrap_push_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    push_i |=> st_r.sp == SPW'($past(st_r.sp) + 1'b1))  // [R13]
    else $error("stack pointer did not wrap on push");
  wrap_pop_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (pop_i && !push_i) |=> st_r.sp == SPW'($past(st_r.sp) - 1'b1))  // [R20]
    else $error("stack pointer did not wrap on pop");
  push_pop_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    push_i ##1 (pop_i && !push_i) |-> top_o == $past(push_data_i))  // [R11]
    else $error("pop did not return last pushed value");
endmodule : pcs_stack
`default_nettype wire

// ---- hw/pcs_page.sv ----
// Forms branch and computed-jump addresses from the latch.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_defs.svh"
module pcs_page #(
  parameter int PROG_WORDS = `PCS_PROG_WORDS
) (
  // Inputs.
  input  wire logic [`PCS_LATCH_W-1:0]  latch_i,
  input  wire logic [`PCS_BRANCH_W-1:0] target_i,
  input  wire logic [7:0]               low_i,
  // Addresses.
  output logic      [`PCS_PC_W-1:0]     branch_pc_o,
  output logic      [`PCS_PC_W-1:0]     low_pc_o
);
  import pcs_pkg::*;

  initial begin
    if (PROG_WORDS < 2048 || PROG_WORDS > 8192) $error("PROG_WORDS out of range");
  end

  // Bit 4 only counts above 4K words.
  localparam logic BIT4_USED = (PROG_WORDS > 4096);  // [R16] [R17]

  logic bit4;  // Latch bit 4 after variant masking.

  // Build both candidate addresses.
  always_comb begin
    bit4 = latch_i[4] & BIT4_USED;                                 // [R16]
    branch_pc_o = {bit4, latch_i[3], target_i};                   // [R06]
    low_pc_o    = {bit4, latch_i[3:0], low_i};                    // [R05] [R07]
  end
endmodule : pcs_page
`default_nettype wire

// ---- dv/pcs_latch_model.sv ----
// Core-side model of the high-byte latch that software loads.
`timescale 1ns/1ps
`default_nettype none
module pcs_latch_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // Software write of the latch.
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  // Latch contents seen by the core.
  output logic      [7:0] latch_o
);
  // Software selects the page before any far branch.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      latch_o <= 8'h00;
    end else if (wr_i) begin
      latch_o <= wr_data_i;
    end
  end
endmodule : pcs_latch_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the sequencing unit.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pcs_pkg::*;
  logic        clk_i, reset_n_i, lat_wr;
  logic [7:0]  lat_data, latch, low, low_s;
  logic [12:0] pc, pc_s;
  logic [12:0] saved [1:9];
  pcs_req_t    req;
  int          errors, tests_run;

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Full-size unit and a 4K-word unit share all stimulus.
  pcs_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .req_i(req),
    .latch_i(latch), .pc_o(pc), .pc_low_byte_o(low));
  pcs_top #(.PROG_WORDS(4096)) u_small (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .req_i(req), .latch_i(latch), .pc_o(pc_s), .pc_low_byte_o(low_s));
  pcs_latch_model u_latch (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .wr_i(lat_wr), .wr_data_i(lat_data), .latch_o(latch));

  // Compares and counts one value.
  task automatic check(input logic [12:0] got, input logic [12:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Issues one operation for a single cycle, then holds.
  task automatic op(input pcs_op_t o, input logic [10:0] t,
                    input logic [7:0] d, input logic k);
    @(posedge clk_i);
    req <= '{op: o, target: t, low_data: d, ret_kind_lit: k};
    @(posedge clk_i);
    req.op <= PCS_OP_HOLD;
    #1;
  endtask : op

  // Loads the latch as software would.
  task automatic set_latch(input logic [7:0] v);
    @(posedge clk_i);
    lat_wr   <= 1'b1;
    lat_data <= v;
    @(posedge clk_i);
    lat_wr   <= 1'b0;
  endtask : set_latch

  // Low-byte writes and stepping over the top of memory.
  task automatic t_wrlow;
    set_latch(8'hFD);
    op(PCS_OP_WRLOW, 11'h000, 8'hA5, 1'b0);
    check(pc, 13'h1DA5);
    check({5'h00, low}, 13'h00A5);
    check(pc_s, 13'h0DA5);
    set_latch(8'h1F);
    op(PCS_OP_WRLOW, 11'h000, 8'hFF, 1'b0);
    op(PCS_OP_STEP, 11'h000, 8'h00, 1'b0);
    check(pc, 13'h0000);
  endtask : t_wrlow

  // Paged branch, call and both return kinds.
  task automatic t_branch;
    set_latch(8'h18);
    op(PCS_OP_BRANCH, 11'h2C3, 8'h00, 1'b0);
    check(pc, 13'h1AC3);
    check(pc_s, 13'h0AC3);
    set_latch(8'h00);
    op(PCS_OP_CALL, 11'h123, 8'h00, 1'b0);
    check(pc, 13'h0123);
    op(PCS_OP_RETURN, 11'h000, 8'h00, 1'b1);
    check(pc, 13'h1AC4);
    check({5'h00, latch}, 13'h0000);
    op(PCS_OP_VECTOR, 11'h000, 8'h00, 1'b0);
    check(pc, 13'h0004);
    op(PCS_OP_RETURN, 11'h000, 8'h00, 1'b0);
    check(pc, 13'h1AC4);
  endtask : t_branch

  // Nine calls and nine returns wrap silently.
  task automatic t_wrap;
    for (int i = 1; i <= 9; i++) begin
      saved[i] = pc + 13'h0001;
      op(PCS_OP_CALL, 11'(i * 16), 8'h00, 1'b0);
    end
    for (int j = 9; j >= 2; j--) begin
      op(PCS_OP_RETURN, 11'h000, 8'h00, 1'b0);
      check(pc, saved[j]);
    end
    op(PCS_OP_RETURN, 11'h000, 8'h00, 1'b0);
    check(pc, saved[9]);
  endtask : t_wrap

  // Reset in mid-run clears the counter.
  task automatic t_reset;
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    check(pc, 13'h0000);
  endtask : t_reset

  task automatic end_of_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // Watchdog far beyond the fewer than one hundred cycles needed.
  initial begin
    #100000;
    errors++;
    end_of_test();
  end

  initial begin
    req       = '{op: PCS_OP_HOLD, default: '0};
    lat_wr    = 1'b0;
    lat_data  = 8'h00;
    reset_n_i = 1'b0;
    errors    = 0;
    tests_run = 0;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    #1;
    check(pc, 13'h0000);
    t_wrlow();
    t_branch();
    t_wrap();
    t_reset();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
